// [src/adcs_pkg.sv]
package adcs_pkg;

  // ==========================================================
  // register map (byte-wide registers, one per address)
  localparam int unsigned    ADDR_W            = 3;
  localparam logic [2:0]     ADDR_CTRL_ONE     = 3'h0;
  localparam logic [2:0]     ADDR_CTRL_TWO     = 3'h1;
  localparam logic [2:0]     ADDR_RES_UPPER    = 3'h2;
  localparam logic [2:0]     ADDR_RES_LOWER    = 3'h3;
  localparam logic [2:0]     ADDR_IRQ_STATUS   = 3'h4;
  localparam logic [2:0]     ADDR_IRQ_CLEAR    = 3'h5;
  localparam logic [2:0]     ADDR_IRQ_ENABLE   = 3'h6;

  // ==========================================================
  // field positions of control_reg_one
  localparam int unsigned    CTRL1_CHAN_LSB    = 4;
  localparam int unsigned    CTRL1_DONE_BIT    = 3;
  localparam int unsigned    CTRL1_BUSY_BIT    = 2;
  localparam int unsigned    CTRL1_START_BIT   = 0;

  // field positions of control_reg_two
  localparam int unsigned    CTRL2_EIGHT_BIT   = 7;
  localparam int unsigned    CTRL2_SAMPLE_LSB  = 5;
  localparam int unsigned    CTRL2_TRIGSEL_BIT = 4;
  localparam int unsigned    CTRL2_IRQEN_BIT   = 3;
  localparam int unsigned    CTRL2_CONT_BIT    = 2;
  localparam int unsigned    CTRL2_CLKSEL_LSB  = 0;

  // interrupt status / clear / enable layout
  localparam int unsigned    IRQ_DONE_BIT      = 0;
  localparam int unsigned    IRQ_OVERRUN_BIT   = 1;

  // ==========================================================
  // reset values
  localparam logic [7:0]     CTRL_RESET        = 8'h00;
  localparam logic [7:0]     RESULT_RESET      = 8'h00;
  localparam logic [1:0]     IRQ_RESET         = 2'h0;

  // ==========================================================
  // timing counts in converter clock periods
  localparam logic [4:0]     COMPARE_TICKS     = 5'h0a;
  localparam logic [4:0]     SAMPLE_TICKS_0    = 5'h04;
  localparam logic [4:0]     SAMPLE_TICKS_1    = 5'h07;
  localparam logic [4:0]     SAMPLE_TICKS_2    = 5'h0a;
  localparam logic [4:0]     SAMPLE_TICKS_3    = 5'h10;

  // ==========================================================
  // conversion sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STARTUP,
    ST_SAMPLE,
    ST_COMPARE,
    ST_FINISH
  } adcs_state_type;

endpackage : adcs_pkg

// [src/adcs_prescaler.sv]
module adcs_prescaler
  import adcs_pkg::*;
#(
  parameter int unsigned CNT_W = 3
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // divider select and enable out
  input  wire logic [1:0] clk_sel,
  output logic            tick
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } adcs_presc_type;

  adcs_presc_type r;
  adcs_presc_type next_r;
  logic [CNT_W-1:0] mask;

  // free running so the phase of a start against the converter clock varies
  always_comb begin
    next_r     = r;
    next_r.cnt = r.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    mask       = CNT_W'((1 << clk_sel) - 1);
  end

  assign tick = ((r.cnt & mask) == mask); // RL19

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

endmodule : adcs_prescaler

// [src/adcs_top.sv]
// Notes on behaviour
// RL1 - ten-bit result: top two bits in upper bits 1:0, rest in lower byte
// RL2 - eight-bit select puts the whole eight-bit result in the lower byte
// RL3 - both result registers are read-only; writes change nothing
// RL4 - after an eight-bit conversion the upper result bits read zero
// RL5 - results change only at conversion end; earlier value readable meanwhile
// RL6 - software reads results and clears done flag before next conversion ends
// RL7 - software changes channel only when idle; clears continuous trigger first
// RL8 - reset, stop or watch mode halts conversion and clears busy
// RL9 - interrupt held while done flag and its enable are both one
// RL10 - restart in the finishing cycle still sets the done flag
// RL11 - sampling lasts the selected number of converter clock periods
// RL12 - compare lasts ten converter clock periods plus one machine clock
// RL13 - startup takes two machine clocks up to one machine plus one converter clock
// RL14 - conversion ends after startup, sampling and compare phases in sum
// RL15 - one phase counter on machine clock advances on converter clock enables
// RL16 - done flag set at end; write zero clears, one ignored, rmw reads one
// RL17 - busy is one for the whole conversion, zero otherwise, not writable
// RL18 - sample codes 00 to 11 give 4, 7, 10, 16 converter clocks
// RL19 - converter clock is machine clock divided by 1, 2, 4 or 8
//
// Decided for this implementation: the strobed register port and the address map.
module adcs_top
  import adcs_pkg::*;
(
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic              reg_rmw,
  output logic      [7:0]        reg_rdata,
  // power modes and trigger pin
  input  wire logic              low_power,
  input  wire logic              trigger_pin,
  // analog core
  input  wire logic [9:0]        ana_result,
  output logic      [3:0]        ana_channel,
  output logic                   ana_power,
  output logic                   ana_sample,
  output logic                   ana_compare,
  // interrupt
  output logic                   irq
);

  // ==========================================================
  // state
  typedef struct packed {
    adcs_state_type st;
    logic [4:0]     cnt;
    logic [3:0]     chan;
    logic           eight;
    logic [1:0]     smp;
    logic           trig_sel;
    logic           irq_en;
    logic           cont;
    logic [1:0]     clk_sel;
    logic           done;
    logic [7:0]     res_hi;
    logic [7:0]     res_lo;
    logic [1:0]     ev;
    logic [1:0]     ev_en;
    logic [7:0]     rdata;
    logic [2:0]     sync;
    logic           trig_lvl;
  } adcs_regs_type;

  adcs_regs_type r;
  adcs_regs_type next_r;

  logic       tick;
  logic       trig_rise;
  logic       start_sw;
  logic       start_hw;
  logic       start_req;
  logic       finish;
  logic       wr_ctrl1;
  logic [4:0] smp_ticks;
  logic [7:0] ctrl1_rd;
  logic [7:0] ctrl2_rd;

  // ==========================================================
  // converter clock enable
  adcs_prescaler #(
    .CNT_W   (3)
  ) adcs_prescaler_inst (
    .clk     (clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .clk_sel (r.clk_sel),
    .tick    (tick)
  );

  // ==========================================================
  // start sources
  // filtered level moves only when the second and third stages agree
  assign trig_rise = (r.sync[1] == r.sync[2]) && r.sync[2] && !r.trig_lvl;
  assign wr_ctrl1  = reg_wr && (reg_addr == ADDR_CTRL_ONE);
  // software start is ignored while continuous trigger is on
  assign start_sw  = wr_ctrl1 && reg_wdata[CTRL1_START_BIT] && !r.cont;
  assign start_hw  = r.cont && r.trig_sel && trig_rise;
  assign start_req = start_sw || start_hw;
  assign finish    = (r.st == ST_FINISH);

  always_comb begin
    unique case (r.smp) // RL18
      2'h0: smp_ticks = SAMPLE_TICKS_0;
      2'h1: smp_ticks = SAMPLE_TICKS_1;
      2'h2: smp_ticks = SAMPLE_TICKS_2;
      2'h3: smp_ticks = SAMPLE_TICKS_3;
    endcase
  end

  // ==========================================================
  // read views
  always_comb begin
    ctrl1_rd                                   = 8'h00;
    ctrl1_rd[CTRL1_CHAN_LSB+3:CTRL1_CHAN_LSB]  = r.chan;
    ctrl1_rd[CTRL1_DONE_BIT]                   = r.done || reg_rmw; // RL16
    ctrl1_rd[CTRL1_BUSY_BIT]                   = (r.st != ST_IDLE); // RL17
    ctrl2_rd                                   = 8'h00;
    ctrl2_rd[CTRL2_EIGHT_BIT]                  = r.eight;
    ctrl2_rd[CTRL2_SAMPLE_LSB+1:CTRL2_SAMPLE_LSB] = r.smp;
    ctrl2_rd[CTRL2_TRIGSEL_BIT]                = r.trig_sel;
    ctrl2_rd[CTRL2_IRQEN_BIT]                  = r.irq_en;
    ctrl2_rd[CTRL2_CONT_BIT]                   = r.cont;
    ctrl2_rd[CTRL2_CLKSEL_LSB+1:CTRL2_CLKSEL_LSB] = r.clk_sel;
  end

  // ==========================================================
  // next state
  always_comb begin
    next_r          = r;
    next_r.sync     = {r.sync[1:0], trigger_pin};
    if (r.sync[1] == r.sync[2]) begin
      next_r.trig_lvl = r.sync[2];
    end

    // register writes
    if (wr_ctrl1) begin
      next_r.chan = reg_wdata[CTRL1_CHAN_LSB+3:CTRL1_CHAN_LSB];
      if (!reg_wdata[CTRL1_DONE_BIT]) begin
        next_r.done = 1'b0; // RL16
      end
    end
    if (reg_wr && (reg_addr == ADDR_CTRL_TWO)) begin
      next_r.eight    = reg_wdata[CTRL2_EIGHT_BIT];
      next_r.smp      = reg_wdata[CTRL2_SAMPLE_LSB+1:CTRL2_SAMPLE_LSB];
      next_r.trig_sel = reg_wdata[CTRL2_TRIGSEL_BIT];
      next_r.irq_en   = reg_wdata[CTRL2_IRQEN_BIT];
      next_r.cont     = reg_wdata[CTRL2_CONT_BIT];
      next_r.clk_sel  = reg_wdata[CTRL2_CLKSEL_LSB+1:CTRL2_CLKSEL_LSB];
    end
    if (reg_wr && (reg_addr == ADDR_IRQ_CLEAR)) begin
      next_r.ev = r.ev & ~reg_wdata[1:0];
    end
    if (reg_wr && (reg_addr == ADDR_IRQ_ENABLE)) begin
      next_r.ev_en = reg_wdata[1:0];
    end
    // result addresses take no write at all
    // RL3

    // sequencer, counter advances only on converter clock enables
    unique case (r.st) // RL15
      ST_IDLE: begin
      end
      ST_STARTUP: begin
        // start cycle plus wait for the next converter edge
        if (tick) begin // RL13
          next_r.st  = ST_SAMPLE;
          next_r.cnt = 5'h00;
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          next_r.cnt = r.cnt + 5'h01;
          if (r.cnt == smp_ticks - 5'h01) begin // RL11
            next_r.st  = ST_COMPARE;
            next_r.cnt = 5'h00;
          end
        end
      end
      ST_COMPARE: begin
        if (tick) begin
          next_r.cnt = r.cnt + 5'h01;
          if (r.cnt == COMPARE_TICKS - 5'h01) begin // RL12
            next_r.st = ST_FINISH;
          end
        end
      end
      ST_FINISH: begin
        // one extra machine clock closes the compare phase
        next_r.st = ST_IDLE; // RL14
        if (r.eight) begin
          next_r.res_hi = RESULT_RESET; // RL4
          next_r.res_lo = ana_result[9:2]; // RL2
        end else begin
          next_r.res_hi = {6'h00, ana_result[9:8]}; // RL1
          next_r.res_lo = ana_result[7:0]; // RL1
        end
        // set wins over a clear in the same cycle
        next_r.done = 1'b1; // RL10
        next_r.ev[IRQ_DONE_BIT] = 1'b1;
        if (r.done) begin
          next_r.ev[IRQ_OVERRUN_BIT] = 1'b1;
        end
      end
    endcase

    // restart from any state, including the finishing one
    if (start_req) begin
      next_r.st  = ST_STARTUP;
      next_r.cnt = 5'h00;
    end
    if (low_power) begin
      next_r.st  = ST_IDLE; // RL8
      next_r.cnt = 5'h00;
    end

    // read data stands for one cycle only
    next_r.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL_ONE:   next_r.rdata = ctrl1_rd;
        ADDR_CTRL_TWO:   next_r.rdata = ctrl2_rd;
        ADDR_RES_UPPER:  next_r.rdata = r.res_hi; // RL5
        ADDR_RES_LOWER:  next_r.rdata = r.res_lo; // RL5
        ADDR_IRQ_STATUS: next_r.rdata = {6'h00, r.ev};
        ADDR_IRQ_ENABLE: next_r.rdata = {6'h00, r.ev_en};
        default:         next_r.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r          <= '0; // RL8
      r.st       <= ST_IDLE;
      r.res_hi   <= RESULT_RESET;
      r.res_lo   <= RESULT_RESET;
      r.ev       <= IRQ_RESET;
      r.ev_en    <= IRQ_RESET;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata   = r.rdata;
  assign ana_channel = r.chan;
  assign ana_power   = (r.st != ST_IDLE); // RL17
  assign ana_sample  = (r.st == ST_SAMPLE);
  assign ana_compare = (r.st == ST_COMPARE);
  assign irq         = (r.done && r.irq_en) || (|(r.ev & r.ev_en)); // RL9

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_finish;
    clk_en && finish;
  endsequence

  sequence s_quiet;
    clk_en && !finish;
  endsequence

  property p_hold_result;
    s_quiet |=> $stable(r.res_lo) && $stable(r.res_hi);
  endproperty
  a_hold_result: assert property (p_hold_result) else $error("result changed outside conversion end"); // RL5

  property p_ro_result;
    (reg_wr && reg_addr == ADDR_RES_LOWER) ##0 s_quiet |=> $stable(r.res_lo);
  endproperty
  a_ro_result: assert property (p_ro_result) else $error("write altered result"); // RL3

  property p_ten_bit;
    s_finish ##0 !r.eight |=> r.res_hi == {6'h00, $past(ana_result[9:8])} && r.res_lo == $past(ana_result[7:0]);
  endproperty
  a_ten_bit: assert property (p_ten_bit) else $error("ten-bit packing wrong"); // RL1

  property p_eight_bit;
    s_finish ##0 r.eight |=> r.res_hi == 8'h00 && r.res_lo == $past(ana_result[9:2]);
  endproperty
  a_eight_bit: assert property (p_eight_bit) else $error("eight-bit packing wrong"); // RL4

  property p_done_set;
    s_finish |=> r.done ##1 1'b1;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set at end"); // RL10

  property p_done_clear;
    (wr_ctrl1 && !reg_wdata[CTRL1_DONE_BIT]) ##0 s_quiet |=> !r.done;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag not cleared"); // RL16

  property p_halt;
    (clk_en && low_power) |=> !ana_power;
  endproperty
  a_halt: assert property (p_halt) else $error("busy survived low power"); // RL8

  property p_irq;
    s_finish ##0 r.irq_en && !(reg_wr && reg_addr == ADDR_CTRL_TWO) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt dropped while pending"); // RL9

  property p_start;
    (clk_en && start_req && !low_power) |=> ana_power && r.st == ST_STARTUP;
  endproperty
  a_start: assert property (p_start) else $error("start did not raise busy"); // RL17

  property p_compare_end;
    (clk_en && r.st == ST_COMPARE && tick && r.cnt == 5'h09 && !start_req && !low_power) |=> finish;
  endproperty
  a_compare_end: assert property (p_compare_end) else $error("compare length wrong"); // RL12

  property p_sample_end;
    (clk_en && ana_sample && tick && r.cnt == smp_ticks - 5'h01 && !start_req && !low_power) |=> ana_compare;
  endproperty
  a_sample_end: assert property (p_sample_end) else $error("sample length wrong"); // RL11

  property p_startup_end;
    (clk_en && r.st == ST_STARTUP && tick && !start_req && !low_power) |=> ana_sample && r.cnt == 5'h00;
  endproperty
  a_startup_end: assert property (p_startup_end) else $error("startup did not hand over to sampling"); // RL13

  property p_busy_drop;
    s_finish ##0 !start_req |=> !ana_power;
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("busy outlived the conversion"); // RL17

  property p_restart;
    s_finish ##0 (start_req && !low_power) |=> r.done && r.st == ST_STARTUP;
  endproperty
  a_restart: assert property (p_restart) else $error("restart at end lost done or start"); // RL10

  property p_rd_lower;
    (clk_en && reg_rd && reg_addr == ADDR_RES_LOWER) |=> reg_rdata == $past(r.res_lo);
  endproperty
  a_rd_lower: assert property (p_rd_lower) else $error("lower result read wrong"); // RL5

endmodule : adcs_top

// [tb/adcs_core_model.sv]
module adcs_core_model (
  // clock
  input  wire logic       clk,
  // core control and result
  input  wire logic [3:0] ana_channel,
  input  wire logic       ana_power,
  output logic      [9:0] ana_result
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // fixed code per channel while powered; toggles when off so a stale read shows
  initial ana_result = 10'h155;
  always @(posedge clk) begin
    if (ana_power) begin
      ana_result <= {ana_channel, 6'h2b};
    end else begin
      ana_result <= ~ana_result;
    end
  end
endmodule : adcs_core_model

// [tb/adcs_top_bench.sv]
module adcs_top_bench
  import adcs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk, rst, clk_en, reg_wr, reg_rd, reg_rmw, low_power, trigger_pin;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0]        reg_wdata, reg_rdata;
  logic [9:0]        ana_result;
  logic [3:0]        ana_channel;
  logic              ana_power, ana_sample, ana_compare, irq;
  int                fails, compares, b, sm, cm, lo, dv;
  int                stab[4] = '{4, 7, 10, 16};

  adcs_top adcs_top_inst (.clk(clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rmw(reg_rmw), .reg_rdata(reg_rdata), .low_power(low_power),
    .trigger_pin(trigger_pin), .ana_result(ana_result), .ana_channel(ana_channel), .ana_power(ana_power),
    .ana_sample(ana_sample), .ana_compare(ana_compare), .irq(irq));
  adcs_core_model adcs_core_model_inst (.clk(clk), .ana_channel(ana_channel), .ana_power(ana_power),
    .ana_result(ana_result));

  // ==========================================
  // bus tasks: one strobe cycle each, one idle edge between
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic m, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a; reg_rmw <= m; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0; reg_rmw <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic rchk(input string name, input logic [2:0] a, input logic m, input logic [7:0] e);
    logic [7:0] v;
    rd(a, m, v);
    chk(name, {8'h00, e}, {8'h00, v});
  endtask : rchk

  task automatic wait_idle();
    int n;
    n = 0;
    while (ana_power !== 1'b1 && n < 100) begin @(posedge clk); #1 n++; end
    while (ana_power === 1'b1 && n < 900) begin @(posedge clk); #1 n++; end
    @(posedge clk);
    #1;
  endtask : wait_idle

  // start by software and count phase lengths at the core pins
  task automatic conv(input logic [7:0] c2, input logic [3:0] ch);
    wr(ADDR_CTRL_TWO, c2);
    wr(ADDR_CTRL_ONE, {ch, 4'h1});
    b = 0; sm = 0; cm = 0;
    for (int i = 0; i < 400; i++) begin
      #1 b += int'(ana_power); sm += int'(ana_sample); cm += int'(ana_compare);
      if (b > 0 && ana_power !== 1'b1) break;
      @(posedge clk);
    end
  endtask : conv

  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // a hang past the longest expected run ends it as a failure
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    complete_run();
  end

  // ==========================================
  initial begin
    rst = 1'b1; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_rmw = 1'b0;
    low_power = 1'b0; trigger_pin = 1'b0; reg_addr = '0; reg_wdata = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rchk("reset_value", 3'(a), 1'b0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 4; s++) begin
        dv = 1 << k;
        conv({1'b0, 2'(s), 3'h0, 2'(k)}, 4'h9);
        lo = (stab[s] + 10) * dv + 2;
        chk("sample_len", 16'(stab[s] * dv), 16'(sm));
        chk("compare_len", 16'(10 * dv), 16'(cm));
        chk("busy_len", 16'h1, 16'(b >= lo && b <= lo + dv - 1));
      end
    end
    rchk("upper_10", ADDR_RES_UPPER, 1'b0, 8'h02);
    rchk("lower_10", ADDR_RES_LOWER, 1'b0, 8'h6b);
    wr(ADDR_CTRL_ONE, 8'h90);
    wr(ADDR_RES_UPPER, 8'hff);
    wr(ADDR_RES_LOWER, 8'h00);
    rchk("upper_ro", ADDR_RES_UPPER, 1'b0, 8'h02);
    rchk("lower_ro", ADDR_RES_LOWER, 1'b0, 8'h6b);
    wr(ADDR_CTRL_TWO, 8'h80);
    wr(ADDR_CTRL_ONE, 8'h61);
    rchk("lower_old", ADDR_RES_LOWER, 1'b0, 8'h6b);
    rchk("busy_set", ADDR_CTRL_ONE, 1'b0, 8'h64);
    wait_idle();
    rchk("upper_8", ADDR_RES_UPPER, 1'b0, 8'h00);
    rchk("lower_8", ADDR_RES_LOWER, 1'b0, 8'h6a);
    rchk("done_set", ADDR_CTRL_ONE, 1'b0, 8'h68);
    wr(ADDR_CTRL_ONE, 8'h68);
    rchk("done_w1", ADDR_CTRL_ONE, 1'b0, 8'h68);
    wr(ADDR_CTRL_ONE, 8'h60);
    rchk("done_w0", ADDR_CTRL_ONE, 1'b0, 8'h60);
    rchk("done_rmw", ADDR_CTRL_ONE, 1'b1, 8'h68);
    // irq through the control enable, then through the status path
    wr(ADDR_IRQ_CLEAR, 8'h03);
    rchk("status_clr", ADDR_IRQ_STATUS, 1'b0, 8'h00);
    conv(8'h08, 4'h6);
    wait_idle();
    chk("irq_on", 16'h1, {15'h0, irq});
    wr(ADDR_CTRL_ONE, 8'h60);
    @(posedge clk);
    #1 chk("irq_off", 16'h0, {15'h0, irq});
    wr(ADDR_IRQ_ENABLE, 8'h01);
    rchk("enable_rd", ADDR_IRQ_ENABLE, 1'b0, 8'h01);
    conv(8'h00, 4'h6);
    wait_idle();
    rchk("status_rd", ADDR_IRQ_STATUS, 1'b0, 8'h01);
    chk("irq_status", 16'h1, {15'h0, irq});
    wr(ADDR_IRQ_CLEAR, 8'h01);
    wr(ADDR_CTRL_ONE, 8'h60);
    wr(ADDR_IRQ_ENABLE, 8'h00);
    conv(8'h00, 4'h6);
    wait_idle();
    chk("irq_masked", 16'h0, {15'h0, irq});
    // restart taken in the finishing cycle
    wr(ADDR_CTRL_ONE, 8'h60);
    wr(ADDR_CTRL_ONE, 8'h61);
    repeat (14) @(posedge clk);
    wr(ADDR_CTRL_ONE, 8'h61);
    rchk("restart_done", ADDR_CTRL_ONE, 1'b0, 8'h6c);
    wait_idle();
    wr(ADDR_CTRL_ONE, 8'h60);
    // halt by low power, then by reset
    wr(ADDR_CTRL_ONE, 8'h61);
    repeat (5) @(posedge clk);
    low_power <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("lp_halt", 16'h0, {15'h0, ana_power});
    @(posedge clk);
    low_power <= 1'b0;
    rchk("lp_flags", ADDR_CTRL_ONE, 1'b0, 8'h60);
    // continuous trigger start; stop it before touching the channel
    wr(ADDR_CTRL_TWO, 8'h14);
    @(posedge clk);
    trigger_pin <= 1'b1;
    repeat (4) @(posedge clk);
    trigger_pin <= 1'b0;
    wait_idle();
    rchk("trig_done", ADDR_CTRL_ONE, 1'b0, 8'h68);
    wr(ADDR_CTRL_TWO, 8'h00);
    wr(ADDR_CTRL_ONE, 8'h30);
    wr(ADDR_CTRL_ONE, 8'h31);
    repeat (5) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("rst_halt", 16'h0, {15'h0, ana_power});
    @(posedge clk);
    rst <= 1'b0;
    rchk("rst_flags", ADDR_CTRL_ONE, 1'b0, 8'h00);
    rchk("rst_lower", ADDR_RES_LOWER, 1'b0, 8'h00);
    complete_run();
  end
endmodule : adcs_top_bench
